/* hw/rpm_pkg.sv */
// Package for the receive modulation control register bank
package rpm_pkg;
   // ---------------------------------------------------------------
   // Register layout
   // ---------------------------------------------------------------
   localparam logic [7:0] RPM_RESET_VALUE    = 8'h00;
   localparam logic [7:0] RPM_WRITE_MASK     = 8'h7f;
   localparam int         RPM_BIT_RESERVED   = 7;
   localparam int         RPM_BIT_BAND       = 6;
   localparam int         RPM_BIT_UNLOCK     = 5;
   localparam int         RPM_BIT_DESCR      = 4;
   localparam int         RPM_BIT_EQ_UPPER   = 3;
   localparam int         RPM_BIT_EQ_LOWER   = 2;
   localparam int         RPM_BIT_RX_ENABLE  = 1;
   // ---------------------------------------------------------------
   // Descrambler constants
   // ---------------------------------------------------------------
   localparam logic [6:0] RPM_ONES_RUN       = 7'h40;
   localparam int         RPM_SCR_LEN        = 17;
   localparam int         RPM_TAP_A          = 13;
   localparam int         RPM_TAP_B          = 16;

   typedef enum logic [1:0] {
      RPM_EQ_NONE,
      RPM_EQ_LOW,
      RPM_EQ_MEDIUM,
      RPM_EQ_HIGH
   } rpm_eq_type;

   typedef enum logic {
      RPM_BAND_400_620,
      RPM_BAND_300_620
   } rpm_band_type;

   typedef struct packed {
      rpm_band_type band;
      logic         unlock;
      logic         descr_on;
      rpm_eq_type   eq_level;
      logic         rx_enable;
   } rpm_ctrl_type;

   typedef struct packed {
      logic call_progress;
      logic carrier;
      logic answer_tone;
      logic unscrambled_mark;
   } rpm_detect_type;

   typedef struct packed {
      logic [7:0]             ctrl;
      logic [RPM_SCR_LEN-1:0] shift;
      logic [6:0]             ones_run;
      logic                   invert_next;
      logic                   data_out;
      logic                   data_valid;
      rpm_detect_type         detect;
   } rpm_state_type;
endpackage

/* hw/rpm_rx_mode_control.sv */
// Receive modulation control register with descrambler and detector gating
//
// Behaviour
// (R1) Software writes zero to reserved bit 7.
// (R2) Band select one gives 300-620 Hz detector band, zero gives 400-620 Hz.
// (R3) Unlock and descrambler enable set: after 64 consecutive input ones, invert next descrambler output.
// (R4) Unlock clear: no ones-run detection and no inversion.
// (R5) Software keeps unlock cleared until handshaking has finished.
// (R6) Descrambler enable set routes received data through the descrambler.
// (R7) Descrambler enable clear passes received data unmodified.
// (R8) Bits 3:2 select receive equaliser level: none, low, medium, high.
// (R9) All detect outputs, tone and unscrambled mark, operate only while receive enable set.
`timescale 1ns/1ps
module rpm_rx_mode_control (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic                   reg_write,
   input  wire logic [7:0]             reg_wdata,
   output      logic [7:0]             reg_rdata,
   input  wire logic                   rx_bit_valid,
   input  wire logic                   rx_bit,
   input  wire rpm_pkg::rpm_detect_type raw_detect,
   output      logic                   data_out,
   output      logic                   data_valid,
   output      rpm_pkg::rpm_detect_type detect_out,
   output      rpm_pkg::rpm_ctrl_type   ctrl_out
);
   import rpm_pkg::*;

   rpm_state_type s_q;
   rpm_state_type s_d;
   logic          scr_bit;
   logic          unlock;
   logic          descr_on;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d      = s_q;
      unlock   = s_q.ctrl[RPM_BIT_UNLOCK];
      descr_on = s_q.ctrl[RPM_BIT_DESCR];
      scr_bit  = rx_bit ^ s_q.shift[RPM_TAP_A] ^ s_q.shift[RPM_TAP_B];
      // (R1) Reserved bit held zero
      if (reg_write) begin
         s_d.ctrl = reg_wdata & RPM_WRITE_MASK;
      end
      s_d.data_valid = rx_bit_valid;
      if (rx_bit_valid) begin
         s_d.shift = {s_q.shift[RPM_SCR_LEN-2:0], rx_bit};
         if (descr_on) begin
            // (R6) Descrambled path
            s_d.data_out = scr_bit ^ (unlock & s_q.invert_next);
         end else begin
            // (R7) Bypass unmodified
            s_d.data_out = rx_bit;
         end
         if (descr_on && s_q.invert_next) begin
            s_d.invert_next = 1'b0;
         end
         // (R3) Ones run detection
         if (unlock && descr_on) begin
            if (!rx_bit) begin
               s_d.ones_run = '0;
            end else if (s_q.ones_run == RPM_ONES_RUN - 7'h01) begin
               s_d.ones_run    = '0;
               s_d.invert_next = 1'b1;
            end else begin
               s_d.ones_run = s_q.ones_run + 7'h01;
            end
         end
      end
      // (R4) Detection disabled
      if (!unlock) begin
         s_d.ones_run    = '0;
         s_d.invert_next = 1'b0;
      end
      // (R9) Detector gating
      if (s_q.ctrl[RPM_BIT_RX_ENABLE]) begin
         s_d.detect = raw_detect;
      end else begin
         s_d.detect = '0;
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_q      <= '0;
         s_q.ctrl <= RPM_RESET_VALUE;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs from state
   // ---------------------------------------------------------------
   assign reg_rdata  = s_q.ctrl;
   assign data_out   = s_q.data_out;
   assign data_valid = s_q.data_valid;
   assign detect_out = s_q.detect;
   // (R2) Band select to detector
   assign ctrl_out.band      = rpm_band_type'(s_q.ctrl[RPM_BIT_BAND]);
   assign ctrl_out.unlock    = s_q.ctrl[RPM_BIT_UNLOCK];
   assign ctrl_out.descr_on  = s_q.ctrl[RPM_BIT_DESCR];
   // (R8) Equaliser level field
   assign ctrl_out.eq_level  = rpm_eq_type'({s_q.ctrl[RPM_BIT_EQ_UPPER],
                                             s_q.ctrl[RPM_BIT_EQ_LOWER]});
   assign ctrl_out.rx_enable = s_q.ctrl[RPM_BIT_RX_ENABLE];
endmodule

/* test/rpm_rx_mode_control_asserts.sv */
// Checker for the receive modulation control register
`timescale 1ns/1ps
module rpm_rx_mode_control_asserts (
   input wire logic                    clk,
   input wire logic                    reset_n,
   input wire logic                    reg_write,
   input wire logic [7:0]              reg_wdata,
   input wire logic [7:0]              reg_rdata,
   input wire logic                    rx_bit_valid,
   input wire logic                    rx_bit,
   input wire rpm_pkg::rpm_detect_type raw_detect,
   input wire logic                    data_out,
   input wire logic                    data_valid,
   input wire rpm_pkg::rpm_detect_type detect_out,
   input wire rpm_pkg::rpm_ctrl_type   ctrl_out
);
   import rpm_pkg::*;
   logic [16:0] h_q;
   logic [6:0]  run_q;
   logic        arm_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Input history and ones-run tracking
   always_ff @(posedge clk) begin
      if (!reset_n) h_q <= '0;
      else if (rx_bit_valid) h_q <= {h_q[15:0], rx_bit};
      if (!reset_n || !ctrl_out.unlock || !ctrl_out.descr_on) begin
         run_q <= '0;
         arm_q <= 1'b0;
      end else if (rx_bit_valid) begin
         arm_q <= rx_bit && run_q == 7'h3f;
         run_q <= (rx_bit && run_q != 7'h3f) ? run_q + 7'h01 : 7'h00;
      end
   end
   sequence s_scr_bit;
      rx_bit_valid && ctrl_out.descr_on;
   endsequence
   a_reserved_dropped: assert property (
      reg_write |=> reg_rdata == ($past(reg_wdata) & 8'h7f)) else $error("reserved bit kept");
   a_band_field: assert property (
      reg_write |=> ctrl_out.band == $past(reg_wdata[6])) else $error("band field wrong");
   a_eq_field: assert property (
      reg_write |=> ctrl_out.eq_level == $past(reg_wdata[3:2])) else $error("eq field wrong");
   a_scr_path: assert property (
      s_scr_bit |=> data_valid && data_out == $past(rx_bit ^ h_q[13] ^ h_q[16] ^ arm_q))
      else $error("descrambled bit wrong");
   a_no_invert: assert property (
      s_scr_bit ##0 !ctrl_out.unlock |=> data_out == $past(rx_bit ^ h_q[13] ^ h_q[16]))
      else $error("inversion while locked");
   a_bypass_path: assert property (
      rx_bit_valid && !ctrl_out.descr_on |=> data_out == $past(rx_bit)) else $error("bypass bit");
   a_detect_gate: assert property (
      1 |=> detect_out == ($past(ctrl_out.rx_enable) ? $past(raw_detect) : 4'h0))
      else $error("detect gating wrong");
endmodule

/* test/rpm_rx_mode_control_test.sv */
// Testbench for the receive modulation control register
`timescale 1ns/1ps
module rpm_rx_mode_control_test;
   import rpm_pkg::*;
   logic           clk, reset_n, reg_write, rx_bit_valid, rx_bit, data_out, data_valid;
   logic [7:0]     reg_wdata, reg_rdata;
   logic [16:0]    h;
   rpm_detect_type raw_detect, detect_out;
   rpm_ctrl_type   ctrl_out;
   int             failures, n_tests;
   rpm_rx_mode_control dut (.clk, .reset_n, .reg_write, .reg_wdata, .reg_rdata, .rx_bit_valid,
      .rx_bit, .raw_detect, .data_out, .data_valid, .detect_out, .ctrl_out);
   always #25 clk = ~clk;
   task chk(logic [7:0] got, logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   task wr(logic [7:0] v);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_wdata <= v;
      @(posedge clk);
      reg_write <= 1'b0;
      #1;
   endtask
   task send(logic b, logic inv, logic byp);
      @(posedge clk);
      rx_bit_valid <= 1'b1;
      rx_bit <= b;
      @(posedge clk);
      rx_bit_valid <= 1'b0;
      #1 chk({6'h0, data_valid, data_out}, {6'h1, byp ? b : b ^ h[13] ^ h[16] ^ inv});
      h = {h[15:0], b};
   endtask
   task t_fields;
      for (int i = 0; i < 4; i++) begin
         wr(8'h40 | 8'(i << 2));
         chk(reg_rdata, 8'h40 | 8'(i << 2));
         chk({5'h0, ctrl_out.band, ctrl_out.eq_level}, 8'h4 | 8'(i));
      end
   endtask
   task t_detect;
      wr(8'h02);
      chk({7'h0, ctrl_out.band}, 8'h00);
      chk({2'h0, ctrl_out}, 8'h01);
      @(posedge clk) raw_detect <= 4'hb;
      @(posedge clk);
      #1 chk({4'h0, detect_out}, 8'h0b);
      wr(8'h00);
      @(posedge clk);
      #1 chk({4'h0, detect_out}, 8'h00);
   endtask
   task t_unlock;
      wr(8'h30);
      chk({2'h0, ctrl_out}, 8'h18);
      for (int i = 0; i < 64; i++) send(1'b1, 1'b0, 1'b0);
      send(1'b0, 1'b1, 1'b0);
      send(1'b1, 1'b0, 1'b0);
      wr(8'h10);
      for (int i = 0; i < 66; i++) send(1'b1, 1'b0, 1'b0);
   endtask
   task t_bypass;
      wr(8'h00);
      send(1'b1, 1'b0, 1'b1);
      send(1'b0, 1'b0, 1'b1);
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      {clk, reset_n, reg_write, rx_bit_valid, rx_bit, reg_wdata, h, raw_detect} = '0;
      failures = 0;
      n_tests = 0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      t_fields;
      t_detect;
      t_unlock;
      t_bypass;
      wrap_up;
   end
   initial begin
      #100us;
      failures++;
      wrap_up;
   end
endmodule
bind rpm_rx_mode_control rpm_rx_mode_control_asserts u_chk (.clk, .reset_n, .reg_write,
   .reg_wdata, .reg_rdata, .rx_bit_valid, .rx_bit, .raw_detect, .data_out, .data_valid,
   .detect_out, .ctrl_out);
